// ==== ccgen_cfg.svh ====
// constants for the cpu clock generation block
// Notes on behaviour
// R1: a machine cycle is exactly two cpu core clock cycles
// R2: peripheral clock enable runs at half the cpu core clock rate
// R3: oscillator source is one of four, fixed by a flash-stored setting
// R4: cpu core clock is the output of the programmable divider
// R5: crystal source has low, medium and high frequency settings
// R6: clock out pin driven only when enabled and crystal not in use
// R7: clock out also requires the rtc not clocked from the crystal
// R8: clock out runs at half the cpu core clock rate
// R9: software keeps other trim bits intact when changing the enable bit
// R10: configuration enables the reset input pin above 12 mhz
// R11: divider divides by twice its 8-bit setting; zero passes through
// R12: rc select bit switches to the rc oscillator at once, no reset
// R13: wake-up timer holds the clock 992 crystal or 224 rc/wdt cycles
// R14: disabled clock out stops toggling and returns the pin to port use
`ifndef CCGEN_CFG_SVH
`define CCGEN_CFG_SVH
// ****************************************************************
// register map
// ****************************************************************
`define CCGEN_ADDR_TRIM 12'h000
`define CCGEN_ADDR_DIV 12'h004
`define CCGEN_ADDR_CFG 12'h008
`define CCGEN_ADDR_STAT 12'h00c
`define CCGEN_TRIM_RC_BIT 7
`define CCGEN_TRIM_EN_BIT 6
`define CCGEN_TRIM_RST 8'h00
`define CCGEN_DIV_RST 8'h00
`define CCGEN_CFG_RST 8'h00
// ****************************************************************
// timing
// ****************************************************************
`define CCGEN_WAKE_XTAL 10'd992
`define CCGEN_WAKE_RC 10'd224
`endif

// ==== ccgen_pkg.sv ====
// types for the cpu clock generation block
package ccgen_pkg;
  // oscillator source choice stored at flash programming
  typedef enum logic [2:0] {
    CCGEN_SRC_WDT,
    CCGEN_SRC_RC,
    CCGEN_SRC_XTAL_LOW,
    CCGEN_SRC_XTAL_MED,
    CCGEN_SRC_XTAL_HIGH,
    CCGEN_SRC_EXT
  } ccgen_src_t;
  typedef enum logic [1:0] {
    CCGEN_WAKE,
    CCGEN_RUN
  } ccgen_state_t;
endpackage : ccgen_pkg

// ==== ccgen_div.sv ====
// integer divider producing the cpu core clock enable
`timescale 1ns/10ps
`default_nettype none
module ccgen_div #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic osc_en_i,
  input wire logic [WIDTH-1:0] cpu_clock_divider_i,
  output logic cpu_core_en_o
);
  logic [WIDTH:0] count;
  logic [WIDTH:0] limit;
  // divide by 2n, zero passes through
  assign limit = (cpu_clock_divider_i == '0) ? '0 :
                 ({cpu_clock_divider_i, 1'b0} - {{WIDTH{1'b0}}, 1'b1}); // see R11
  // count oscillator ticks, pulse on terminal
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      count <= '0;
      cpu_core_en_o <= 1'b0;
    end else begin
      cpu_core_en_o <= 1'b0;
      if (osc_en_i) begin
        if (count >= limit) begin
          count <= '0;
          cpu_core_en_o <= 1'b1; // see R4
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule : ccgen_div
`default_nettype wire

// ==== ccgen_top.sv ====
// cpu clock generation with apb register access
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ccgen_cfg.svh"
module ccgen_top
  import ccgen_pkg::*;
#(
  parameter logic [5:0] TRIM_FACTORY = 6'h20
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] osc_source_cfg_i,
  input wire logic rtc_uses_xtal_i,
  input wire logic wdt_osc_tick_i,
  input wire logic rc_osc_tick_i,
  input wire logic xtal_osc_tick_i,
  input wire logic ext_clk_tick_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cpu_core_en_o,
  output logic periph_en_o,
  output logic machine_cycle_o,
  output logic clock_out_pin_o,
  output logic clock_out_oe_n_o,
  output logic reset_input_pin_en_o,
  output logic clk_ready_o
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] trim;
  logic [7:0] div_n;
  logic [7:0] cfg;
  ccgen_src_t src;
  ccgen_state_t state;
  logic [9:0] wake_cnt;
  logic osc_tick;
  logic div_en;
  logic core_en;
  logic phase;
  logic clk_out_ok;
  logic wr;
  logic rd;
  // ****************************************************************
  // helpers and apb access
  // ****************************************************************
  // true for any of the three crystal settings
  function automatic logic is_xtal(input ccgen_src_t s);
    is_xtal = (s == CCGEN_SRC_XTAL_LOW) || (s == CCGEN_SRC_XTAL_MED) ||
              (s == CCGEN_SRC_XTAL_HIGH);
  endfunction : is_xtal
  // writes land in the access phase, reads are fetched in setup
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  // source latched after reset release from flash setting
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      src <= CCGEN_SRC_RC;
    end else if (state == CCGEN_WAKE && wake_cnt == '0) begin
      src <= ccgen_src_t'(osc_source_cfg_i); // see R3 R5
    end
  end
  // apb writes; trim written whole, software preserves its low bits
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      trim <= {2'b00, TRIM_FACTORY};
      div_n <= `CCGEN_DIV_RST;
      cfg <= `CCGEN_CFG_RST;
    end else if (wr && pstrb[0]) begin
      unique case (paddr)
        `CCGEN_ADDR_TRIM: trim <= pwdata[7:0]; // see R9
        `CCGEN_ADDR_DIV: div_n <= pwdata[7:0];
        `CCGEN_ADDR_CFG: cfg <= pwdata[7:0]; // see R10
        default: ;
      endcase
    end
  end
  // apb read data and answer, zero wait states
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == `CCGEN_ADDR_TRIM ||
                 paddr == `CCGEN_ADDR_DIV || paddr == `CCGEN_ADDR_CFG ||
                 paddr == `CCGEN_ADDR_STAT);
      if (rd) begin
        unique case (paddr)
          `CCGEN_ADDR_TRIM: prdata <= {24'h000000, trim};
          `CCGEN_ADDR_DIV: prdata <= {24'h000000, div_n};
          `CCGEN_ADDR_CFG: prdata <= {24'h000000, cfg};
          `CCGEN_ADDR_STAT: prdata <= {29'h00000000, clk_out_ok,
                                       state == CCGEN_RUN, src == CCGEN_SRC_RC};
          default: prdata <= '0;
        endcase
      end
    end
  end
  // ****************************************************************
  // oscillator selection and wake-up
  // ****************************************************************
  // the rc bit bypasses the latched source, so software can leave a slow
  // crystal without a reset; the wake-up timer is not run again
  // oscillator selection, rc bit overrides at once
  always_comb begin
    if (trim[`CCGEN_TRIM_RC_BIT]) begin
      osc_tick = rc_osc_tick_i; // see R12
    end else begin
      unique case (src)
        CCGEN_SRC_WDT: osc_tick = wdt_osc_tick_i;
        CCGEN_SRC_RC: osc_tick = rc_osc_tick_i;
        CCGEN_SRC_EXT: osc_tick = ext_clk_tick_i;
        default: osc_tick = xtal_osc_tick_i;
      endcase
    end
  end
  // wake-up hold-off counted in oscillator ticks
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= CCGEN_WAKE;
      wake_cnt <= '0;
    end else begin
      unique case (state)
        CCGEN_WAKE: begin
          if (osc_tick || wake_cnt == '0) begin
            wake_cnt <= wake_cnt + 10'd1;
          end
          if (wake_cnt != '0 && osc_tick &&
              wake_cnt >= (is_xtal(src) ? `CCGEN_WAKE_XTAL : `CCGEN_WAKE_RC)) begin
            state <= CCGEN_RUN; // see R13
          end
        end
        CCGEN_RUN: ;
      endcase
    end
  end
  // ****************************************************************
  // cpu core clock divider
  // ****************************************************************
  // divider only sees ticks once the hold-off has expired
  assign div_en = osc_tick && (state == CCGEN_RUN);
  ccgen_div #(
    .WIDTH(8)
  ) u_div (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .osc_en_i(div_en),
    .cpu_clock_divider_i(div_n),
    .cpu_core_en_o(core_en)
  );
  // ****************************************************************
  // clock out conditions
  // ****************************************************************
  // clock out allowed only off crystal and with rtc off crystal
  assign clk_out_ok = trim[`CCGEN_TRIM_EN_BIT] && !rtc_uses_xtal_i && // see R7
                      (trim[`CCGEN_TRIM_RC_BIT] || !is_xtal(src)); // see R6
  // ****************************************************************
  // core, peripheral and machine cycle pulses
  // ****************************************************************
  // phase picks every second core pulse
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      phase <= 1'b0;
    end else if (core_en) begin
      phase <= !phase;
    end
  end
  // pulses registered so every output leaves a flip-flop
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cpu_core_en_o <= 1'b0;
      periph_en_o <= 1'b0;
      machine_cycle_o <= 1'b0;
    end else begin
      cpu_core_en_o <= core_en;
      periph_en_o <= core_en && phase; // see R2
      machine_cycle_o <= core_en && phase; // see R1
    end
  end
  // ****************************************************************
  // status outputs
  // ****************************************************************
  // reset pin enable and ready flag
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reset_input_pin_en_o <= 1'b0;
      clk_ready_o <= 1'b0;
    end else begin
      reset_input_pin_en_o <= cfg[0];
      clk_ready_o <= state == CCGEN_RUN;
    end
  end
  // ****************************************************************
  // clock out pin
  // ****************************************************************
  // pin handed back to port use whenever the conditions drop
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      clock_out_oe_n_o <= 1'b1;
    end else begin
      clock_out_oe_n_o <= !clk_out_ok; // see R14
    end
  end
  // toggles on each core pulse, parked low while released
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      clock_out_pin_o <= 1'b0;
    end else if (!clk_out_ok) begin
      clock_out_pin_o <= 1'b0; // see R14
    end else if (core_en) begin
      clock_out_pin_o <= !clock_out_pin_o; // see R8
    end
  end
endmodule : ccgen_top
`default_nettype wire

// ==== ccgen_props.sv ====
// assertions on the clock generation block ports
`timescale 1ns/10ps
`default_nettype none
module ccgen_props (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] osc_source_cfg_i,
  input wire logic rtc_uses_xtal_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_core_en_o,
  input wire logic periph_en_o,
  input wire logic machine_cycle_o,
  input wire logic clock_out_pin_o,
  input wire logic clock_out_oe_n_o,
  input wire logic clk_ready_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  mach_cyc_a: assert property (machine_cycle_o |-> cpu_core_en_o ##1 !machine_cycle_o)
    else $error("machine cycle off core pulse");
  periph_half_a: assert property (periph_en_o |-> cpu_core_en_o ##1 !periph_en_o)
    else $error("peripheral pulse off core pulse");
  xtal_oe_a: assert property (!clock_out_oe_n_o |-> !(osc_source_cfg_i inside {3'h2, 3'h3, 3'h4}))
    else $error("clock out driven on crystal");
  rtc_oe_a: assert property (rtc_uses_xtal_i && $past(rtc_uses_xtal_i) |-> clock_out_oe_n_o)
    else $error("clock out driven with rtc on crystal");
  pin_idle_a: assert property (clock_out_oe_n_o |-> !clock_out_pin_o)
    else $error("pin not idle when released");
  pin_rate_a: assert property (!clock_out_oe_n_o && !$past(clock_out_oe_n_o)
    && $changed(clock_out_pin_o) |-> cpu_core_en_o || $past(cpu_core_en_o))
    else $error("pin toggled without core pulse");
  wake_hold_a: assert property (!clk_ready_o |-> !cpu_core_en_o)
    else $error("core pulse during wake");
  apb_wait_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  apb_err_a: assert property (pready && !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c})
    |-> pslverr)
    else $error("unmapped access not refused");
  cover property ($rose(clk_ready_o));
  cover property (!clock_out_oe_n_o && $changed(clock_out_pin_o));
  cover property (pready && pslverr);
endmodule : ccgen_props
bind ccgen_top ccgen_props i_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .osc_source_cfg_i(osc_source_cfg_i), .rtc_uses_xtal_i(rtc_uses_xtal_i), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .cpu_core_en_o(cpu_core_en_o), .periph_en_o(periph_en_o), .machine_cycle_o(machine_cycle_o),
  .clock_out_pin_o(clock_out_pin_o), .clock_out_oe_n_o(clock_out_oe_n_o),
  .clk_ready_o(clk_ready_o));
`default_nettype wire

// ==== ccgen_sync_model.sv ====
// external device that follows the clock out pin
`timescale 1ns/10ps
`default_nettype none
module ccgen_sync_model (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  input wire logic oe_n_i,
  output logic [15:0] edges_o
);
  logic last;
  // counts rising edges only while the pin is driven
  always_ff @(posedge core_clk_i) begin
    last <= pin_i;
    if (!rst_n_i) edges_o <= 16'h0000;
    else if (!oe_n_i && pin_i && !last) edges_o <= edges_o + 16'h0001;
  end
endmodule : ccgen_sync_model
`default_nettype wire

// ==== cpu_clock_generation_tb.sv ====
// self-checking bench for the clock generation block
`timescale 1ns/10ps
`default_nettype none
module cpu_clock_generation_tb;
  logic core_clk = 1'b0, rst_n = 1'b0, tick = 1'b0, rtc = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, core_en, per_en, mc, pin, oe_n, rpin, rdy;
  logic [15:0] edges, e0;
  logic [2:0] src_cfg = 3'h1;
  logic [1:0] ph = 2'h0;
  int n_errors = 0, n_checks = 0, c = 0;
  ccgen_top i_dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .osc_source_cfg_i(src_cfg),
    .rtc_uses_xtal_i(rtc), .wdt_osc_tick_i(tick), .rc_osc_tick_i(tick),
    .xtal_osc_tick_i(ph == 2'h0),
    .ext_clk_tick_i(tick), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_core_en_o(core_en), .periph_en_o(per_en), .machine_cycle_o(mc), .clock_out_pin_o(pin),
    .clock_out_oe_n_o(oe_n), .reset_input_pin_en_o(rpin), .clk_ready_o(rdy));
  ccgen_sync_model i_ext (.core_clk_i(core_clk), .rst_n_i(rst_n), .pin_i(pin), .oe_n_i(oe_n),
    .edges_o(edges));
  // clock, oscillator tick every other cycle
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) tick <= ~tick;
  // crystal ticks every fourth cycle, slower than the rc
  always @(posedge core_clk) ph <= ph + 2'h1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, answer taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // cycles between two pulses of core (0) or peripheral (1) enable
  task automatic gap(input bit k, input int exp);
    int n;
    n = 0;
    do begin @(posedge core_clk); #1; end while ((k ? per_en : core_en) !== 1'b1);
    do begin @(posedge core_clk); #1; n++; end while ((k ? per_en : core_en) !== 1'b1);
    chk(n, exp);
  endtask : gap
  task automatic t_wake(input int lo, input int hi);
    c = 0;
    while (rdy !== 1'b1) begin
      @(posedge core_clk);
      c++;
    end
    chk(c >= lo && c <= hi, 1);
    $display("wake done");
  endtask : t_wake
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h20);
    apb(1'b0, 12'h004, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(e, 1);
    chk(r, 32'h0);
    apb(1'b1, 12'h008, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(rpin, 1);
    $display("regs done");
  endtask : t_regs
  task automatic t_div;
    gap(1'b0, 2);
    gap(1'b1, 4);
    apb(1'b1, 12'h004, 32'h3);
    repeat (30) @(posedge core_clk);
    gap(1'b0, 12);
    apb(1'b1, 12'h004, 32'h0);
    $display("divider done");
  endtask : t_div
  task automatic t_clk;
    apb(1'b0, 12'h000, 32'h0);
    apb(1'b1, 12'h000, r | 32'h40);
    apb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h60);
    repeat (5) @(posedge core_clk);
    #1;
    chk(oe_n, 0);
    e0 = edges;
    repeat (40) @(posedge core_clk);
    #1;
    chk(edges - e0, 10);
    @(posedge core_clk);
    rtc <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk({oe_n, pin}, 2'b10);
    $display("clock out done");
  endtask : t_clk
  // second reset with a crystal source, then the rc select override
  task automatic t_xtal;
    @(posedge core_clk);
    rst_n <= 1'b0;
    rtc <= 1'b0;
    src_cfg <= 3'h4;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_wake(3955, 3985);
    gap(1'b0, 4);
    apb(1'b0, 12'h00c, 32'h0);
    chk(r, 32'h2);
    apb(1'b0, 12'h000, 32'h0);
    apb(1'b1, 12'h000, r | 32'h40);
    repeat (3) @(posedge core_clk);
    chk(oe_n, 1);
    apb(1'b1, 12'h000, r | 32'h80);
    repeat (4) @(posedge core_clk);
    gap(1'b0, 2);
    $display("crystal done");
  endtask : t_xtal
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_wake(440, 460);
    t_regs;
    t_div;
    t_clk;
    t_xtal;
    tally_and_finish;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    tally_and_finish;
  end
endmodule : cpu_clock_generation_tb
`default_nettype wire
